// [dsp_defs.svh]
`ifndef DSP_DEFS_SVH
`define DSP_DEFS_SVH
// register indices; byte address is four times the index
`define DSP_IDX_PWR 8'h87
`define DSP_IDX_CTL0 8'h98
`define DSP_IDX_BUF0 8'h99
`define DSP_IDX_BUF1 8'h9A
`define DSP_IDX_AUX1 8'hA2
`define DSP_IDX_TMR3 8'hC4
`define DSP_IDX_CTL1 8'hF8
`define DSP_IDX_ISTAT 8'h10
`define DSP_IDX_IMASK 8'h11
// field positions
`define DSP_B_DBL 7
`define DSP_B_FESEL 6
`define DSP_B_BRCK 5
`define DSP_B_PX 2
// reset values, writable masks and interrupt field width
`define DSP_RST_REG 8'h00
`define DSP_PWR_MASK 8'hDF
`define DSP_AUX_MASK 8'hED
`define DSP_IRQ_W 6
// bit periods, in clocks or timer overflows
`define DSP_M0_DIV 7'h0C
`define DSP_M0_FAST 7'h02
`define DSP_M2_DIV 7'h40
`define DSP_M2_FAST 7'h20
`define DSP_M13_DIV 7'h20
`define DSP_M13_FAST 7'h10
`endif

// [dsp_pkg.sv]
package dsp_pkg;
    typedef enum logic [1:0] {
        DSP_SH_IDLE = 2'b00,
        DSP_SH_RUN = 2'b01
    } dsp_shift_t;
    typedef enum logic [1:0] {
        DSP_RX_IDLE = 2'b00,
        DSP_RX_START = 2'b01,
        DSP_RX_DATA = 2'b11
    } dsp_rx_t;
endpackage : dsp_pkg

// [dsp_serial_peer.sv]
`timescale 1ns/1ns

module dsp_serial_peer (
    input wire logic mclk, // system clock
    input wire logic lineIn, // line driven by the port
    output logic lineOut // line into the port
);
    // released line idles high, as with a pull-up
    initial lineOut = 1'b1;

    task automatic sendFrame(input logic [7:0] d, input int per, input logic stopBit);
        logic [9:0] fr;
        fr = {stopBit, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            lineOut <= fr[i];
            repeat (per - 1) @(posedge mclk);
        end
        @(posedge mclk);
        lineOut <= 1'b1;
    endtask : sendFrame

    // samples eleven bit slots from the start edge; a hang leaves all ones
    task automatic recvFrame(input int per, output logic [10:0] fr);
        int n;
        n = 0;
        while (lineIn !== 1'b0 && n < 5000) begin
            @(posedge mclk);
            n++;
        end
        repeat (per / 2) @(posedge mclk);
        for (int i = 0; i < 11; i++) begin
            fr[i] = lineIn;
            if (i < 10) repeat (per) @(posedge mclk);
        end
    endtask : recvFrame
endmodule : dsp_serial_peer

// [dsp_uart.sv]
// Operation
// - port0 double bit doubles mode2, timer1 modes
// - port0 select routes bit7 to mode/fe
// - port1 double bit doubles mode 2 only
// - port1 select routes bit7 to mode/fe
// - mode bits pick 8, 10 or 11-bit frames
// - mode0 clock/12, or /2 with multiproc bit
// - port0 modes 1,3: overflow/32, doubled /16
// - port0 mode2: clock/64, doubled /32
// - port1 modes 1,3: timer3 overflow/16 only
// - buffer write goes transmit, read gives receive
// - buffer write starts transmission
// - pin exchange swaps port0 pins at once
// - transmit-done flag set at stop bit start, mode 0 after last bit
// - receive-done flag set after stop sample, mode 0 after last bit
// - ten-bit frame: start, 8 lsb-first, stop
`timescale 1ns/1ns
`include "dsp_defs.svh"

module dsp_port (
    input wire logic mclk, // system clock
    input wire logic srst, // synchronous reset
    input wire logic wrCtl, // control register write
    input wire logic wrBuf, // data buffer write
    input wire logic [7:0] wrData, // write data
    input wire logic feSel, // bit 7 shows framing error
    input wire logic dblM2, // mode 2 halved divisor
    input wire logic dbl13, // modes 1,3 divisor 16
    input wire logic ovfTick, // baud timer overflow pulse
    input wire logic rxdIn, // filtered receive line
    output logic [7:0] ctlRd, // control readback
    output logic [7:0] rxData, // receive register
    output logic txd, // transmit line or shift clock
    output logic rxdOut, // mode 0 data out
    output logic rxdOe, // mode 0 data enable
    output logic txEv, // transmit done pulse
    output logic rxEv, // receive done pulse
    output logic feEv // framing error pulse
);
    function automatic logic [6:0] bitPeriod(input logic [1:0] m, input logic s2, input logic d2,
                                             input logic d13);
        if (m == 2'b00)
            return s2 ? `DSP_M0_FAST : `DSP_M0_DIV;
        else if (m == 2'b10)
            return d2 ? `DSP_M2_FAST : `DSP_M2_DIV;
        else
            return d13 ? `DSP_M13_FAST : `DSP_M13_DIV;
    endfunction : bitPeriod

    logic sm0_q, sm1_q, sm2_q, ren_q, tb8_q, rb8_q, ti_q, ri_q, fe_q;
    logic [10:0] sh_q;
    logic [3:0] shLeft_q;
    logic [6:0] shCnt_q;
    logic shRx_q;
    dsp_pkg::dsp_shift_t shSt_q;
    dsp_pkg::dsp_rx_t rxSt_q;
    logic [6:0] rxCnt_q;
    logic [3:0] rxN_q;
    logic [8:0] rxSr_q;
    logic rxPrev_q;

    wire [1:0] mode = {sm0_q, sm1_q};
    wire async = mode != 2'b00;
    wire m1 = mode == 2'b01;
    wire unit = sm1_q ? ovfTick : 1'b1;
    wire [6:0] period = bitPeriod(mode, sm2_q, dblM2, dbl13);
    wire [6:0] halfPer = {1'b0, period[6:1]};

    // shared shifter: async transmit, or mode 0 in either direction
    wire shBusy = shSt_q == dsp_pkg::DSP_SH_RUN;
    wire shEdge = shBusy & unit & (shCnt_q == period - 7'h01);
    wire lastBit = shEdge & (shLeft_q == 4'h1);
    // a write while busy is dropped; the frame in flight is not corrupted
    wire txGo = wrBuf & !shBusy;
    wire m0RxGo = !async & ren_q & !ri_q & !shBusy & !wrBuf;
    wire [3:0] frameLen = !async ? 4'h8 : (m1 ? 4'hA : 4'hB);
    wire [10:0] txFrame = async ? {1'b1, m1 | tb8_q, wrData, 1'b0} : {3'b111, wrData};
    wire [10:0] shIn = {rxdIn, sh_q[10:1]};

    assign txEv = shEdge & !shRx_q & (async ? shLeft_q == 4'h2 : shLeft_q == 4'h1);

    always_ff @(posedge mclk) begin
        if (srst) begin
            shSt_q <= dsp_pkg::DSP_SH_IDLE;
            sh_q <= 11'h7FF;
            shLeft_q <= 4'h0;
            shCnt_q <= 7'h00;
            shRx_q <= 1'b0;
        end else begin
            case (shSt_q)
                dsp_pkg::DSP_SH_IDLE: begin
                    shCnt_q <= 7'h00;
                    shLeft_q <= frameLen;
                    if (txGo | m0RxGo) begin
                        shSt_q <= dsp_pkg::DSP_SH_RUN;
                        shRx_q <= !txGo;
                        sh_q <= txGo ? txFrame : 11'h7FF;
                    end
                end
                dsp_pkg::DSP_SH_RUN: begin
                    if (shEdge) begin
                        shCnt_q <= 7'h00;
                        shLeft_q <= shLeft_q - 4'h1;
                        sh_q <= shIn;
                        if (lastBit)
                            shSt_q <= dsp_pkg::DSP_SH_IDLE;
                    end else if (unit) begin
                        shCnt_q <= shCnt_q + 7'h01;
                    end
                end
                default: shSt_q <= dsp_pkg::DSP_SH_IDLE;
            endcase
        end
    end

    // pin drivers; mode 0 clock is low in the first half of each bit
    wire txdD = !shBusy ? 1'b1 : (async ? sh_q[0] : shCnt_q >= halfPer);
    always_ff @(posedge mclk) begin
        if (srst) begin
            txd <= 1'b1;
            rxdOut <= 1'b1;
            rxdOe <= 1'b0;
        end else begin
            txd <= txdD;
            rxdOut <= sh_q[0];
            rxdOe <= shBusy & !async & !shRx_q;
        end
    end

    // asynchronous receiver, sampling mid-bit
    wire rxFall = rxPrev_q & !rxdIn;
    wire [6:0] rxTarget = rxSt_q == dsp_pkg::DSP_RX_START ? halfPer - 7'h01 : period - 7'h01;
    wire rxTick = unit & (rxCnt_q == rxTarget);
    wire [3:0] nData = m1 ? 4'h8 : 4'h9;
    wire stopTick = rxTick & (rxSt_q == dsp_pkg::DSP_RX_DATA) & (rxN_q == nData);
    wire ninth = m1 ? rxdIn : rxSr_q[8];
    wire [7:0] rxByte = m1 ? rxSr_q[8:1] : rxSr_q[7:0];
    wire rxAccept = stopTick & !ri_q & (!sm2_q | ninth);
    assign feEv = stopTick & !rxdIn;
    assign rxEv = rxAccept | (lastBit & shRx_q);

    always_ff @(posedge mclk) begin
        if (srst) begin
            rxSt_q <= dsp_pkg::DSP_RX_IDLE;
            rxCnt_q <= 7'h00;
            rxN_q <= 4'h0;
            rxSr_q <= 9'h000;
            rxPrev_q <= 1'b1;
        end else begin
            rxPrev_q <= rxdIn;
            rxCnt_q <= rxTick ? 7'h00 : (unit ? rxCnt_q + 7'h01 : rxCnt_q);
            case (rxSt_q)
                dsp_pkg::DSP_RX_IDLE: begin
                    rxCnt_q <= 7'h00;
                    rxN_q <= 4'h0;
                    if (async & ren_q & rxFall)
                        rxSt_q <= dsp_pkg::DSP_RX_START;
                end
                dsp_pkg::DSP_RX_START: begin
                    // a start bit that does not hold to mid-bit is noise
                    if (rxTick)
                        rxSt_q <= rxdIn ? dsp_pkg::DSP_RX_IDLE : dsp_pkg::DSP_RX_DATA;
                end
                dsp_pkg::DSP_RX_DATA: begin
                    if (stopTick) begin
                        rxSt_q <= dsp_pkg::DSP_RX_IDLE;
                    end else if (rxTick) begin
                        rxSr_q <= {rxdIn, rxSr_q[8:1]};
                        rxN_q <= rxN_q + 4'h1;
                    end
                end
                default: rxSt_q <= dsp_pkg::DSP_RX_IDLE;
            endcase
        end
    end

    // control bits; hardware set wins over a software write
    always_ff @(posedge mclk) begin
        if (srst) begin
            {sm0_q, sm1_q, sm2_q, ren_q, tb8_q, rb8_q, ti_q, ri_q} <= `DSP_RST_REG;
            fe_q <= 1'b0;
            rxData <= `DSP_RST_REG;
        end else begin
            if (wrCtl) begin
                if (!feSel)
                    sm0_q <= wrData[7];
                {sm1_q, sm2_q, ren_q, tb8_q} <= wrData[6:3];
            end
            fe_q <= feEv | ((wrCtl & feSel) ? wrData[7] : fe_q);
            ti_q <= txEv | (wrCtl ? wrData[1] : ti_q);
            ri_q <= rxEv | (wrCtl ? wrData[0] : ri_q);
            rb8_q <= rxAccept ? ninth : (wrCtl ? wrData[2] : rb8_q);
            if (rxAccept)
                rxData <= rxByte;
            else if (lastBit & shRx_q)
                rxData <= shIn[10:3];
        end
    end

    assign ctlRd = {feSel ? fe_q : sm0_q, sm1_q, sm2_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence txLaunch;
        txGo && m1 ##1 shBusy;
    endsequence
    sequence stopLow;
        stopTick && !rxdIn;
    endsequence

    txStart_a: assert property (txGo |=> shBusy && !txGo) else $error("write did not start shifter");
    frameTen_a: assert property (txLaunch |-> shLeft_q == 4'hA ##1 !txd) else $error("bad mode 1 frame");
    m0Rate_a: assert property (mode == 2'b00 |-> period == (sm2_q ? 7'h02 : 7'h0C)) else $error("mode 0 rate");
    m2Rate_a: assert property (mode == 2'b10 |-> period == (dblM2 ? 7'h20 : 7'h40)) else $error("mode 2 rate");
    m13Rate_a: assert property (sm1_q |-> period == (dbl13 ? 7'h10 : 7'h20)) else $error("mode 1/3 rate");
    tiSet_a: assert property (txEv |=> ti_q ##1 (ti_q || $past(wrCtl))) else $error("done flag lost");
    riSet_a: assert property (rxAccept |=> ri_q && rxData == $past(rxByte)) else $error("receive not stored");
    feSet_a: assert property (stopLow |=> fe_q) else $error("framing error missed");
    bufSplit_a: assert property (wrBuf && !rxEv |=> rxData == $past(rxData)) else $error("write hit rx reg");
    feRoute_a: assert property (wrCtl && feSel |=> sm0_q == $past(sm0_q)) else $error("bit 7 misrouted");
endmodule : dsp_port

module dsp_uart (
    input wire logic mclk, // system clock, 25 MHz
    input wire logic srst, // synchronous reset
    input wire logic [9:0] wb_adr_i, // byte address
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    input wire logic wb_we_i, // write enable
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic wb_stb_i, // strobe
    input wire logic wb_cyc_i, // cycle
    output logic wb_ack_o, // acknowledge
    input wire logic t1Ovf, // timer 1 overflow pulse
    input wire logic t3Ovf, // timer 3 overflow pulse
    input wire logic p06In, // pin P0.6 level
    output logic p06Out, // pin P0.6 drive value
    output logic p06Oe, // pin P0.6 drive enable
    input wire logic p07In, // pin P0.7 level
    output logic p07Out, // pin P0.7 drive value
    output logic p07Oe, // pin P0.7 drive enable
    output logic p1TxdOut, // port 1 transmit pin
    input wire logic p1RxdIn, // port 1 receive pin level
    output logic p1RxdOut, // port 1 receive pin drive
    output logic p1RxdOe, // port 1 receive pin enable
    output logic irq // level interrupt
);
    logic ack_q;
    logic [31:0] dat_q;
    logic [7:0] pwr_q, aux_q, tmr3_q;
    logic [`DSP_IRQ_W-1:0] istat_q, imask_q;
    logic [2:0] sy0_q, sy1_q;
    logic filt0_q, filt1_q;
    logic [7:0] ctl0, ctl1, rx0, rx1;
    logic txd0, rxo0, rxe0, txd1;
    logic tx0Ev, rx0Ev, fe0Ev, tx1Ev, rx1Ev, fe1Ev;

    wire req = wb_cyc_i & wb_stb_i;
    wire wr = req & ack_q & wb_we_i & wb_sel_i[0];
    wire [7:0] idx = wb_adr_i[9:2];
    wire [7:0] wd = wb_dat_i[7:0];
    wire wrPwr = wr & (idx == `DSP_IDX_PWR);
    wire wrCtl0 = wr & (idx == `DSP_IDX_CTL0);
    wire wrBuf0 = wr & (idx == `DSP_IDX_BUF0);
    wire wrBuf1 = wr & (idx == `DSP_IDX_BUF1);
    wire wrAux = wr & (idx == `DSP_IDX_AUX1);
    wire wrTmr3 = wr & (idx == `DSP_IDX_TMR3);
    wire wrCtl1 = wr & (idx == `DSP_IDX_CTL1);
    wire wrIst = wr & (idx == `DSP_IDX_ISTAT);
    wire wrImk = wr & (idx == `DSP_IDX_IMASK);
    wire [`DSP_IRQ_W-1:0] ev = {fe1Ev, rx1Ev, tx1Ev, fe0Ev, rx0Ev, tx0Ev};

    wire [7:0] rdMux =
        idx == `DSP_IDX_PWR ? pwr_q :
        idx == `DSP_IDX_CTL0 ? ctl0 :
        idx == `DSP_IDX_BUF0 ? rx0 :
        idx == `DSP_IDX_BUF1 ? rx1 :
        idx == `DSP_IDX_AUX1 ? aux_q :
        idx == `DSP_IDX_TMR3 ? tmr3_q :
        idx == `DSP_IDX_CTL1 ? ctl1 :
        idx == `DSP_IDX_ISTAT ? {2'b00, istat_q} :
        idx == `DSP_IDX_IMASK ? {2'b00, imask_q} : 8'h00;

    wire px = aux_q[`DSP_B_PX];
    wire brck = tmr3_q[`DSP_B_BRCK];
    wire dbl0 = pwr_q[`DSP_B_DBL];
    wire ovf0 = brck ? t3Ovf : t1Ovf;
    // doubling only applies when timer 1 is the source
    wire dbl013 = dbl0 & !brck;

    always_ff @(posedge mclk) begin
        if (srst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req & !ack_q;
            dat_q <= {24'h00_0000, rdMux};
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            pwr_q <= `DSP_RST_REG;
            aux_q <= `DSP_RST_REG;
            tmr3_q <= `DSP_RST_REG;
            imask_q <= '0;
            istat_q <= '0;
        end else begin
            if (wrPwr)
                pwr_q <= wd & `DSP_PWR_MASK;
            if (wrAux)
                aux_q <= wd & `DSP_AUX_MASK;
            if (wrTmr3)
                tmr3_q <= wd;
            if (wrImk)
                imask_q <= wd[`DSP_IRQ_W-1:0];
            istat_q <= ev | (istat_q & ~(wrIst ? wd[`DSP_IRQ_W-1:0] : '0));
        end
    end
    assign irq = |(istat_q & imask_q);

    // receive lines: three stages, a change counts once stages two and three agree
    wire raw0 = px ? p06In : p07In;
    always_ff @(posedge mclk) begin
        if (srst) begin
            sy0_q <= 3'h7;
            sy1_q <= 3'h7;
            filt0_q <= 1'b1;
            filt1_q <= 1'b1;
        end else begin
            sy0_q <= {sy0_q[1:0], raw0};
            sy1_q <= {sy1_q[1:0], p1RxdIn};
            if (sy0_q[1] == sy0_q[2])
                filt0_q <= sy0_q[2];
            if (sy1_q[1] == sy1_q[2])
                filt1_q <= sy1_q[2];
        end
    end

    // swapping mid-frame is not guarded; software must avoid it
    assign p06Out = px ? rxo0 : txd0;
    assign p06Oe = px ? rxe0 : 1'b1;
    assign p07Out = px ? txd0 : rxo0;
    assign p07Oe = px ? 1'b1 : rxe0;

    dsp_port port0 (
        .mclk(mclk), .srst(srst), .wrCtl(wrCtl0), .wrBuf(wrBuf0), .wrData(wd),
        .feSel(pwr_q[`DSP_B_FESEL]), .dblM2(dbl0), .dbl13(dbl013), .ovfTick(ovf0),
        .rxdIn(filt0_q), .ctlRd(ctl0), .rxData(rx0), .txd(txd0), .rxdOut(rxo0), .rxdOe(rxe0),
        .txEv(tx0Ev), .rxEv(rx0Ev), .feEv(fe0Ev)
    );
    dsp_port port1 (
        .mclk(mclk), .srst(srst), .wrCtl(wrCtl1), .wrBuf(wrBuf1), .wrData(wd),
        .feSel(tmr3_q[`DSP_B_FESEL]), .dblM2(tmr3_q[`DSP_B_DBL]), .dbl13(1'b1), .ovfTick(t3Ovf),
        .rxdIn(filt1_q), .ctlRd(ctl1), .rxData(rx1), .txd(p1TxdOut), .rxdOut(p1RxdOut), .rxdOe(p1RxdOe),
        .txEv(tx1Ev), .rxEv(rx1Ev), .feEv(fe1Ev)
    );

    pinSwap_a: assert property (@(posedge mclk) disable iff (srst)
        px |-> p07Out == txd0 && p07Oe && p06Out == rxo0) else $error("pin exchange wrong");
    dblSrc_a: assert property (@(posedge mclk) disable iff (srst)
        brck |-> !dbl013) else $error("timer 3 source doubled");
endmodule : dsp_uart

// [dsp_uart_tb.sv]
`timescale 1ns/1ns
`include "dsp_defs.svh"

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, got, exp); end end

module dsp_uart_tb;
    typedef struct {
        logic [7:0] ctl;
        logic [7:0] buff;
        logic [1:0] mode;
        logic [7:0] pwr;
        logic [7:0] t3;
        logic [1:0] pin;
        int per;
        logic [7:0] d;
    } dsp_row_t;
    logic mclk, srst, we, stb, ack, tick, irq, rxLine;
    logic [9:0] adr;
    logic [31:0] datI, datO;
    logic p06Out, p06Oe, p07Out, p07Oe, p1TxdOut, p1RxdOut, p1RxdOe;
    logic [1:0] watch;
    int failures = 0;
    int compares = 0;
    wire logic p06Pin = p06Oe ? p06Out : rxLine;
    wire logic p07Pin = p07Oe ? p07Out : rxLine;
    wire logic p1RxPin = p1RxdOe ? p1RxdOut : rxLine;
    wire logic peerIn = (watch == 2'd0) ? p06Pin : ((watch == 2'd1) ? p07Pin : p1TxdOut);
    dsp_row_t rows [9] = '{
        '{`DSP_IDX_CTL0, `DSP_IDX_BUF0, 2'b10, 8'h00, 8'h00, 2'd0, 64, 8'hA5},
        '{`DSP_IDX_CTL0, `DSP_IDX_BUF0, 2'b10, 8'h80, 8'h00, 2'd0, 32, 8'h3C},
        '{`DSP_IDX_CTL0, `DSP_IDX_BUF0, 2'b01, 8'h00, 8'h00, 2'd0, 64, 8'h96},
        '{`DSP_IDX_CTL0, `DSP_IDX_BUF0, 2'b11, 8'h80, 8'h00, 2'd0, 32, 8'h0F},
        '{`DSP_IDX_CTL0, `DSP_IDX_BUF0, 2'b11, 8'h80, 8'h20, 2'd0, 64, 8'hE1},
        '{`DSP_IDX_CTL1, `DSP_IDX_BUF1, 2'b01, 8'h00, 8'h80, 2'd2, 32, 8'h5A},
        '{`DSP_IDX_CTL1, `DSP_IDX_BUF1, 2'b10, 8'h00, 8'h80, 2'd2, 32, 8'hC6},
        '{`DSP_IDX_CTL1, `DSP_IDX_BUF1, 2'b10, 8'h00, 8'h00, 2'd2, 64, 8'h71},
        '{`DSP_IDX_CTL1, `DSP_IDX_BUF1, 2'b11, 8'h80, 8'h00, 2'd2, 32, 8'h2B}
    };
    logic [7:0] regIdx [9] = '{`DSP_IDX_PWR, `DSP_IDX_CTL0, `DSP_IDX_BUF0, `DSP_IDX_BUF1,
        `DSP_IDX_AUX1, `DSP_IDX_TMR3, `DSP_IDX_CTL1, `DSP_IDX_ISTAT, `DSP_IDX_IMASK};

    dsp_uart dut_u (.mclk(mclk), .srst(srst), .wb_adr_i(adr), .wb_dat_i(datI), .wb_dat_o(datO),
        .wb_we_i(we), .wb_sel_i(4'hF), .wb_stb_i(stb), .wb_cyc_i(stb), .wb_ack_o(ack),
        .t1Ovf(tick), .t3Ovf(tick), .p06In(p06Pin), .p06Out(p06Out), .p06Oe(p06Oe),
        .p07In(p07Pin), .p07Out(p07Out), .p07Oe(p07Oe), .p1TxdOut(p1TxdOut), .p1RxdIn(p1RxPin),
        .p1RxdOut(p1RxdOut), .p1RxdOe(p1RxdOe), .irq(irq));
    dsp_serial_peer peer_u (.mclk(mclk), .lineIn(peerIn), .lineOut(rxLine));

    always #20 mclk = ~mclk;
    // overflow pulse every other clock: one overflow period is two clocks
    always @(posedge mclk) tick <= srst ? 1'b0 : ~tick;

    task automatic stop_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test

    task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        adr <= {idx, 2'b00};
        datI <= {24'h000000, wd};
        we <= w;
        stb <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 100);
        rd = datO[7:0];
        stb <= 1'b0;
        if (n >= 100) begin
            failures++;
            stop_test();
        end
        @(posedge mclk);
    endtask : wb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        wb(idx, 1'b1, d, x);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
        logic [7:0] x;
        wb(idx, 1'b0, 8'h00, x);
        `CHK(x, e);
    endtask : rdc

    task automatic txCheck(input dsp_row_t r);
        logic [10:0] fr;
        logic [10:0] e;
        e = (r.mode == 2'b01) ? {2'b11, r.d, 1'b0} : {2'b10, r.d, 1'b0};
        watch = r.pin;
        wr(r.ctl, {r.mode, 6'h00});
        wr(r.buff, r.d);
        peer_u.recvFrame(r.per, fr);
        `CHK(fr, e);
        // next write only once the stop bit has ended
        repeat (r.per) @(posedge mclk);
        rdc(r.ctl, {r.mode, 6'h02});
    endtask : txCheck

    task automatic clkPeriod(input int e);
        int n;
        int m;
        n = 0;
        m = 0;
        while (p06Pin !== 1'b0 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        while (p06Pin !== 1'b1 && m < 100) begin
            @(posedge mclk);
            m++;
        end
        while (p06Pin !== 1'b0 && m < 100) begin
            @(posedge mclk);
            m++;
        end
        `CHK(m, e);
    endtask : clkPeriod

    initial begin
        mclk = 1'b0;
        srst = 1'b1;
        stb = 1'b0;
        we = 1'b0;
        adr = 10'h000;
        datI = 32'h00000000;
        watch = 2'd0;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        foreach (rows[i]) begin
            wr(`DSP_IDX_PWR, rows[i].pwr);
            wr(`DSP_IDX_TMR3, rows[i].t3);
            txCheck(rows[i]);
        end
        rdc(`DSP_IDX_BUF0, 8'h00);
        wr(`DSP_IDX_PWR, 8'h00);
        wr(`DSP_IDX_TMR3, 8'h00);
        wr(`DSP_IDX_ISTAT, 8'h3F);
        wr(`DSP_IDX_CTL0, 8'h50);
        peer_u.sendFrame(8'h5A, 64, 1'b1);
        rdc(`DSP_IDX_BUF0, 8'h5A);
        // mode 1 keeps the received stop bit in the ninth-bit flag
        rdc(`DSP_IDX_CTL0, 8'h55);
        rdc(`DSP_IDX_ISTAT, 8'h02);
        `CHK(irq, 1'b0);
        wr(`DSP_IDX_IMASK, 8'h02);
        `CHK(irq, 1'b1);
        wr(`DSP_IDX_ISTAT, 8'h02);
        `CHK(irq, 1'b0);
        wr(`DSP_IDX_CTL0, 8'h50);
        wr(`DSP_IDX_PWR, 8'h40);
        peer_u.sendFrame(8'hA3, 64, 1'b0);
        rdc(`DSP_IDX_CTL0, 8'hD1);
        wr(`DSP_IDX_PWR, 8'h00);
        rdc(`DSP_IDX_CTL0, 8'h51);
        wr(`DSP_IDX_PWR, 8'h40);
        rdc(`DSP_IDX_CTL0, 8'hD1);
        wr(`DSP_IDX_PWR, 8'h00);
        // pin exchange takes effect at once; it is written here with both directions idle
        wr(`DSP_IDX_AUX1, 8'h04);
        `CHK({p07Oe, p06Oe}, 2'b10);
        txCheck('{`DSP_IDX_CTL0, `DSP_IDX_BUF0, 2'b01, 8'h00, 8'h00, 2'd1, 64, 8'hC3});
        wr(`DSP_IDX_AUX1, 8'h00);
        watch = 2'd0;
        wr(`DSP_IDX_CTL0, 8'h00);
        wr(`DSP_IDX_BUF0, 8'h55);
        clkPeriod(12);
        repeat (120) @(posedge mclk);
        // mode 0 receive with the line idle shifts in all ones
        wr(`DSP_IDX_CTL0, 8'h10);
        repeat (120) @(posedge mclk);
        rdc(`DSP_IDX_BUF0, 8'hFF);
        rdc(`DSP_IDX_CTL0, 8'h11);
        wr(`DSP_IDX_CTL0, 8'h20);
        wr(`DSP_IDX_BUF0, 8'h55);
        clkPeriod(2);
        repeat (40) @(posedge mclk);
        wr(`DSP_IDX_PWR, 8'hFF);
        rdc(`DSP_IDX_PWR, 8'hDF);
        wr(`DSP_IDX_AUX1, 8'hFF);
        rdc(`DSP_IDX_AUX1, 8'hED);
        wr(8'hFF, 8'h55);
        rdc(8'hFF, 8'h00);
        srst <= 1'b1;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        foreach (regIdx[i]) rdc(regIdx[i], 8'h00);
        `CHK(irq, 1'b0);
        `CHK({p1RxdOe, p1RxdOut, p1TxdOut}, 3'b011);
        stop_test();
    end
endmodule : dsp_uart_tb
